/* File: crc8_step.sv */
// One byte step of the link check code
`timescale 1ns/10ps
module crc8_step
  import link_check_pkg::*;
(
  input  wire logic [7:0] crc_in,
  input  wire logic [7:0] data_in,
  output logic      [7:0] crc_out
);

  // ==========================================================================
  // Bitwise shift, most significant data bit first
  always_comb begin
    crc_out = crc_in;
    for (int i = 7; i >= 0; i--) begin
      if (crc_out[7] ^ data_in[i]) begin
        crc_out = {crc_out[6:0], 1'b0} ^ CRC_POLY;
      end else begin
        crc_out = {crc_out[6:0], 1'b0};
      end
    end
  end

endmodule : crc8_step

/* File: level_sync.sv */
// Two flip-flop synchroniser for one level
`timescale 1ns/10ps
module level_sync #(
  parameter logic RESET_VALUE = 1'b0
) (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic d,
  output logic      q
);

  logic meta_reg;

  // ==========================================================================
  // Synchroniser pair; the first stage feeds only the second
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= RESET_VALUE;
      q        <= RESET_VALUE;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule : level_sync

/* File: link_check_pkg.sv */
// Constants, register map and state codes of the serial link check block
package link_check_pkg;

  // ==========================================================================
  // Register map
  localparam logic [6:0] ADDR_CONFIG  = 7'h10;
  localparam logic [6:0] ADDR_STATUS  = 7'h11;
  localparam logic [6:0] ADDR_WIDE_LO = 7'h12;
  localparam logic [6:0] ADDR_WIDE_HI = 7'h13;

  localparam logic [7:0]  CONFIG_RESET = 8'h23;
  localparam logic [7:0]  STATUS_RESET = 8'h00;
  localparam logic [15:0] WIDE_RESET   = 16'h0000;

  // ==========================================================================
  // Configuration fields
  localparam int         EN_HI      = 7;
  localparam int         EN_LO      = 6;
  localparam int         STRICT_BIT = 5;
  localparam logic [1:0] CHECK_OFF  = 2'h0;
  localparam logic [1:0] CHECK_ON   = 2'h1;

  // ==========================================================================
  // Status flags
  localparam int         NOT_READY_BIT = 7;
  localparam int         EDGE_BIT      = 5;
  localparam int         CHECK_BIT     = 3;
  localparam int         PARTIAL_BIT   = 1;
  localparam int         ADDR_BIT      = 0;
  localparam logic [7:0] FLAG_MASK     = 8'hAB;

  // ==========================================================================
  // Frame layout and check code
  localparam int         READ_FLAG_BIT = 7;
  localparam logic [7:0] CRC_POLY      = 8'h07;
  localparam logic [7:0] CRC_INIT      = 8'h00;

  // ==========================================================================
  // Timing
  localparam int         READY_TIME_NS   = 1000;
  localparam int         CLOCK_PERIOD_NS = 25;
  localparam int         READY_CYCLES    =
    (READY_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam logic [5:0] READY_COUNT     = 6'(READY_CYCLES);

  typedef enum logic [2:0] {
    FRAME_IDLE  = 3'b000,
    FRAME_INSTR = 3'b001,
    FRAME_DATA  = 3'b010,
    FRAME_CHECK = 3'b011,
    FRAME_DROP  = 3'b100
  } frame_state_e;

endpackage : link_check_pkg

/* File: link_check_regs.sv */
// Serial link check configuration and fault status registers
//
// What this block does
// - Enable field 00 off, 01 on
// - Enable changes only with complement written together
// - Companion field low bits, resets to 0x3
// - Strict multibyte bit reads constant one
// - Partial multibyte write: no update, flag set
// - Frame before ready sets bit 7
// - Wrong clock edge count sets bit 5
// - Flags sticky, cleared only by writing one
// - Configuration at 0x10, resets to 0x23
// - Status at 0x11, resets zero, bit6 zero
// - Too few bytes sets partial bit 1
// - Missing or wrong check code sets bit 3
`timescale 1ns/10ps
module link_check_regs
  import link_check_pkg::*;
(
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic sdi,
  output logic      sdo,
  output logic      sdo_oe,
  output logic      check_on
);
  import link_check_pkg::*;

  // ==========================================================================
  // Link side: shift in, hand bytes across by toggle
  logic       frame_rst_n;
  logic [2:0] bit_cnt_reg;
  logic [6:0] shift_reg;
  logic [7:0] byte_hold_reg;
  logic       byte_tgl_reg;
  logic       mid_byte_reg;
  logic [6:0] out_shift_reg;
  logic [7:0] rd_byte_reg;
  logic       rd_active_reg;

  // Frame select high clears the bit position, as does device reset
  assign frame_rst_n = rstn & ~cs_n;

  // Bit counter and input shifter; mid_byte marks an unfinished byte
  always_ff @(posedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      bit_cnt_reg  <= 3'h0;
      shift_reg    <= 7'h00;
      mid_byte_reg <= 1'b0;
    end else begin
      bit_cnt_reg  <= bit_cnt_reg + 3'h1;
      shift_reg    <= {shift_reg[5:0], sdi};
      mid_byte_reg <= (bit_cnt_reg != 3'h7);
    end
  end

  // Byte holder survives frame end so the last byte still crosses
  always_ff @(posedge sclk or negedge rstn) begin
    if (!rstn) begin
      byte_hold_reg <= 8'h00;
      byte_tgl_reg  <= 1'b0;
    end else if (bit_cnt_reg == 3'h7) begin
      byte_hold_reg <= {shift_reg, sdi};
      byte_tgl_reg  <= ~byte_tgl_reg;
    end
  end

  // Read data out on the falling edge; rd_byte_reg is settled by the
  // required pause after each byte, so it is taken as a quiet word
  always_ff @(negedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      sdo           <= 1'b0;
      sdo_oe        <= 1'b0;
      out_shift_reg <= 7'h00;
    end else if (bit_cnt_reg == 3'h0) begin
      sdo           <= rd_byte_reg[7];
      sdo_oe        <= rd_active_reg;
      out_shift_reg <= rd_byte_reg[6:0];
    end else begin
      sdo           <= out_shift_reg[6];
      out_shift_reg <= {out_shift_reg[5:0], 1'b0};
    end
  end

  // ==========================================================================
  // Crossings into the system clock
  logic cs_s, tgl_s, mid_s;

  level_sync #(.RESET_VALUE(1'b1)) u_cs_sync (
    .clock (clock),
    .rstn  (rstn),
    .d     (cs_n),
    .q     (cs_s)
  );

  level_sync #(.RESET_VALUE(1'b0)) u_tgl_sync (
    .clock (clock),
    .rstn  (rstn),
    .d     (byte_tgl_reg),
    .q     (tgl_s)
  );

  level_sync #(.RESET_VALUE(1'b0)) u_mid_sync (
    .clock (clock),
    .rstn  (rstn),
    .d     (mid_byte_reg),
    .q     (mid_s)
  );

  logic cs_d1_reg, cs_d2_reg, tgl_d_reg, mid_d1_reg, mid_d2_reg;

  // Frame end is seen one cycle late so a last byte is handled first
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cs_d1_reg  <= 1'b1;
      cs_d2_reg  <= 1'b1;
      tgl_d_reg  <= 1'b0;
      mid_d1_reg <= 1'b0;
      mid_d2_reg <= 1'b0;
    end else begin
      cs_d1_reg  <= cs_s;
      cs_d2_reg  <= cs_d1_reg;
      tgl_d_reg  <= tgl_s;
      mid_d1_reg <= mid_s;
      mid_d2_reg <= mid_d1_reg;
    end
  end

  logic       frame_start, frame_end, byte_ev;
  logic [7:0] rx_byte;
  assign frame_start = cs_d1_reg & ~cs_s;
  assign frame_end   = cs_d1_reg & ~cs_d2_reg;
  assign byte_ev     = tgl_s ^ tgl_d_reg;
  assign rx_byte     = byte_hold_reg;

  // ==========================================================================
  // Ready timer after power-on reset
  logic [5:0] ready_cnt_reg;
  logic       ready_reg;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ready_cnt_reg <= 6'h00;
      ready_reg     <= 1'b0;
    end else if (!ready_reg) begin
      ready_cnt_reg <= ready_cnt_reg + 6'h01;
      ready_reg     <= (ready_cnt_reg == READY_COUNT - 6'h01);
    end
  end

  // ==========================================================================
  // Frame sequencing
  frame_state_e state_reg;
  logic         read_reg;
  logic [6:0]   addr_reg;
  logic [7:0]   crc_acc_reg, crc_next, data_hold_reg;
  logic [1:0]   check_en_reg;
  logic [7:0]   status_reg;
  logic [15:0]  wide_reg;
  logic [7:0]   wide_lo_stage_reg;
  logic         lo_pend_reg;

  crc8_step u_crc (
    .crc_in  (crc_acc_reg),
    .data_in (rx_byte),
    .crc_out (crc_next)
  );

  logic       in_data, check_ok, commit, access;
  logic [7:0] commit_data;
  assign in_data     = byte_ev & (state_reg == FRAME_DATA);
  assign check_ok    = (rx_byte == crc_acc_reg);
  // with checking on, data applies only once its check byte matches
  assign commit      = ~read_reg & ((in_data & ~check_on) |
                       (byte_ev & (state_reg == FRAME_CHECK) & check_ok));
  assign commit_data = check_on ? data_hold_reg : rx_byte;
  assign access      = commit | (in_data & read_reg);

  // Register read view
  function automatic logic [7:0] read_mux(input logic [6:0] a);
    unique case (a)
      // companion reads as complement; strict bit constant one
      ADDR_CONFIG:  read_mux = {check_en_reg, CONFIG_RESET[STRICT_BIT], 3'h0, ~check_en_reg};
      ADDR_STATUS:  read_mux = status_reg;
      ADDR_WIDE_LO: read_mux = wide_reg[7:0];
      ADDR_WIDE_HI: read_mux = wide_reg[15:8];
      default:      read_mux = 8'h00;
    endcase
  endfunction : read_mux

  // Frame state machine and read data publication
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_reg     <= FRAME_IDLE;
      read_reg      <= 1'b0;
      addr_reg      <= 7'h00;
      crc_acc_reg   <= CRC_INIT;
      data_hold_reg <= 8'h00;
      rd_byte_reg   <= 8'h00;
      rd_active_reg <= 1'b0;
    end else if (frame_end) begin
      state_reg     <= FRAME_IDLE;
      rd_active_reg <= 1'b0;
    end else if (frame_start) begin
      state_reg   <= ready_reg ? FRAME_INSTR : FRAME_DROP;
      crc_acc_reg <= CRC_INIT;
    end else if (byte_ev) begin
      unique case (state_reg)
        FRAME_INSTR: begin
          read_reg      <= rx_byte[READ_FLAG_BIT];
          addr_reg      <= rx_byte[6:0];
          crc_acc_reg   <= crc_next;
          rd_byte_reg   <= read_mux(rx_byte[6:0]);
          rd_active_reg <= rx_byte[READ_FLAG_BIT];
          state_reg     <= FRAME_DATA;
        end
        FRAME_DATA: begin
          crc_acc_reg <= crc_next;
          if (read_reg || !check_on) begin
            addr_reg    <= addr_reg + 7'h01;
            rd_byte_reg <= read_mux(addr_reg + 7'h01);
          end else begin
            data_hold_reg <= rx_byte;
            state_reg     <= FRAME_CHECK;
          end
        end
        FRAME_CHECK: begin
          crc_acc_reg <= crc_next;
          addr_reg    <= addr_reg + 7'h01;
          state_reg   <= check_ok ? FRAME_DATA : FRAME_DROP;
        end
        FRAME_IDLE, FRAME_DROP: begin
          state_reg <= state_reg;
        end
        default: begin
          state_reg <= FRAME_DROP;
        end
      endcase
    end
  end

  // ==========================================================================
  // Configuration register
  logic cfg_wr, cfg_pair_ok;
  assign cfg_wr      = commit & (addr_reg == ADDR_CONFIG);
  assign cfg_pair_ok = (commit_data[EN_HI:EN_LO] == ~commit_data[1:0]);

  // reset value; needs the complement in the same write
  // on decoded as the field is stored, so the pin leaves a flop
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      check_en_reg <= CONFIG_RESET[EN_HI:EN_LO];
      check_on     <= (CONFIG_RESET[EN_HI:EN_LO] == CHECK_ON);
    end else if (cfg_wr && cfg_pair_ok) begin
      check_en_reg <= commit_data[EN_HI:EN_LO];
      check_on     <= (commit_data[EN_HI:EN_LO] == CHECK_ON);
    end
  end

  // ==========================================================================
  // Multibyte register, updated only when both bytes arrive
  logic hi_access, lo_access, partial_ev;
  assign lo_access  = access & (addr_reg == ADDR_WIDE_LO);
  assign hi_access  = access & (addr_reg == ADDR_WIDE_HI);
  // too few bytes, from a lone high byte or an orphaned low byte
  assign partial_ev = (hi_access & ~lo_pend_reg) |
                      (lo_pend_reg & ((access & ~hi_access) | frame_end));

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wide_reg          <= WIDE_RESET;
      wide_lo_stage_reg <= 8'h00;
      lo_pend_reg       <= 1'b0;
    end else begin
      if (lo_access) begin
        wide_lo_stage_reg <= commit_data;
      end
      if (hi_access && lo_pend_reg && commit) begin
        wide_reg <= {commit_data, wide_lo_stage_reg};
      end
      lo_pend_reg <= lo_access & ~frame_end;
      if (!access && !frame_end) begin
        lo_pend_reg <= lo_pend_reg;
      end
    end
  end

  // ==========================================================================
  // Fault status flags
  logic [7:0] set_vec, clr_vec;
  logic       addr_bad;
  assign addr_bad = (addr_reg < ADDR_CONFIG) | (addr_reg > ADDR_WIDE_HI);

  // Event and clear vectors
  always_comb begin
    set_vec = 8'h00;
    set_vec[NOT_READY_BIT] = frame_start & ~ready_reg;
    set_vec[EDGE_BIT]      = frame_end & mid_d2_reg;
    set_vec[CHECK_BIT]     = (frame_end & (state_reg == FRAME_CHECK)) |
                             (byte_ev & (state_reg == FRAME_CHECK) & ~check_ok);
    set_vec[PARTIAL_BIT]   = partial_ev;
    set_vec[ADDR_BIT]      = access & addr_bad;
    clr_vec = (commit && addr_reg == ADDR_STATUS) ? (commit_data & FLAG_MASK) : 8'h00;
  end

  // set wins; reserved bits stay zero
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      status_reg <= STATUS_RESET;
    end else begin
      status_reg <= ((status_reg & ~clr_vec) | set_vec) & FLAG_MASK;
    end
  end

  // ==========================================================================
  // Checks
  a_cfg_guard: assert property (@(posedge clock) disable iff (!rstn)
    cfg_wr && !cfg_pair_ok |=> $stable(check_en_reg))
    else $error("check enable changed without complement");
  a_cfg_update: assert property (@(posedge clock) disable iff (!rstn)
    cfg_wr && cfg_pair_ok |=> check_en_reg == $past(commit_data[EN_HI:EN_LO]))
    else $error("check enable not taken");
  a_cfg_view: assert property (@(posedge clock) disable iff (!rstn)
    read_mux(ADDR_CONFIG) inside {8'h23, 8'h62, 8'hA1, 8'hE0})
    else $error("configuration view wrong");
  a_partial_keep: assert property (@(posedge clock) disable iff (!rstn)
    hi_access && !lo_pend_reg |=> $stable(wide_reg) && status_reg[PARTIAL_BIT])
    else $error("partial write changed register");
  a_early_flag: assert property (@(posedge clock) disable iff (!rstn)
    frame_start && !ready_reg |=> status_reg[NOT_READY_BIT] && state_reg == FRAME_DROP)
    else $error("early frame not flagged");
  a_edge_flag: assert property (@(posedge clock) disable iff (!rstn)
    frame_end && mid_d2_reg |=> status_reg[EDGE_BIT])
    else $error("edge count fault not flagged");
  a_flag_sticky: assert property (@(posedge clock) disable iff (!rstn)
    $fell(status_reg[EDGE_BIT]) |-> $past(clr_vec[EDGE_BIT]))
    else $error("flag fell without a write of one");
  a_set_wins: assert property (@(posedge clock) disable iff (!rstn)
    (set_vec & clr_vec) != 8'h00 |=> (status_reg & $past(set_vec)) == $past(set_vec))
    else $error("clear beat a new event");
  a_check_flag: assert property (@(posedge clock) disable iff (!rstn)
    byte_ev && state_reg == FRAME_CHECK && !check_ok |=> status_reg[CHECK_BIT] ##1
    state_reg != FRAME_DATA)
    else $error("bad check code not flagged");

endmodule : link_check_regs

/* File: link_check_regs_bench.sv */
// Self-checking bench for the link check and fault flag registers
`timescale 1ns/10ps
module link_check_regs_bench;
  import link_check_pkg::*;
  logic        clock;
  logic        rstn;
  wire         sclk;
  wire         cs_n;
  wire         sdi;
  wire         sdo;
  wire         sdo_oe;
  wire         check_on;
  int          n_errors;
  int          n_checks;
  logic [15:0] v;
  logic [7:0]  rx;
  logic        on_prev;
  // Config writes, expected readback and expected check state
  logic [7:0]  cw [7] = '{8'h40, 8'h81, 8'hC0, 8'h1F, 8'h42, 8'h80, 8'h03};
  logic [7:0]  ce [7] = '{8'h23, 8'hA1, 8'hE0, 8'h23, 8'h62, 8'h62, 8'h23};
  logic        con [7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};

  link_check_regs link_check_regs_i (
    .clock    (clock),
    .rstn     (rstn),
    .sclk     (sclk),
    .cs_n     (cs_n),
    .sdi      (sdi),
    .sdo      (sdo),
    .sdo_oe   (sdo_oe),
    .check_on (check_on)
  );

  spi_host_model spi_host_model_i (
    .clock (clock),
    .sclk  (sclk),
    .cs_n  (cs_n),
    .sdi   (sdi),
    .sdo   (sdo)
  );

  // ==========================================================================
  // Clock and helpers
  initial clock = 1'b0;
  always #12.5 clock = ~clock;

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Own check code model, kept apart from the design's step module
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) r = r[7] ? ({r[6:0], 1'b0} ^ CRC_POLY) : {r[6:0], 1'b0};
    return r;
  endfunction : crc8

  // Write n bytes low first; with crc set each byte is followed by its check
  task automatic wr(input logic [6:0] a, input logic [15:0] d, input int n, input logic crc);
    logic [7:0] c;
    c = crc8(CRC_INIT, {1'b0, a});
    spi_host_model_i.start();
    spi_host_model_i.shift({1'b0, a}, 8, rx);
    for (int i = 0; i < n; i++) begin
      spi_host_model_i.shift(d[8*i +: 8], 8, rx);
      c = crc8(c, d[8*i +: 8]);
      if (crc) begin
        spi_host_model_i.shift(c, 8, rx);
        c = crc8(c, c);
      end
    end
    spi_host_model_i.stop();
  endtask : wr

  task automatic rd(input logic [6:0] a, input int n, output logic [15:0] q);
    q = 16'h0000;
    spi_host_model_i.start();
    spi_host_model_i.shift({1'b1, a}, 8, rx);
    for (int i = 0; i < n; i++) begin
      spi_host_model_i.shift(8'h00, 8, rx);
      q[8*i +: 8] = rx;
    end
    chk("sdo_oe in read", 16'(sdo_oe), 16'h0001);
    spi_host_model_i.stop();
  endtask : rd

  task automatic rchk(input string what, input logic [6:0] a, input logic [15:0] exp);
    logic [15:0] q;
    rd(a, 1, q);
    chk(what, q, exp);
  endtask : rchk

  task automatic do_reset();
    @(negedge clock);
    rstn = 1'b0;
    repeat (3) @(negedge clock);
    rstn = 1'b1;
  endtask : do_reset

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  // ==========================================================================
  // Watchdog: the whole sequence needs well under a tenth of this
  initial begin
    #1_000_000;
    n_errors++;
    final_report();
  end

  // Main sequence
  initial begin
    rstn = 1'b0;
    n_errors = 0;
    n_checks = 0;
    repeat (3) @(negedge clock);
    rstn = 1'b1;
    repeat (50) @(negedge clock);
    rchk("config reset", ADDR_CONFIG, 16'h0023);
    rchk("status reset", ADDR_STATUS, 16'h0000);
    chk("check_on reset", 16'(check_on), 16'h0000);
    chk("sdo_oe idle", 16'(sdo_oe), 16'h0000);
    $display("test reset values done");
    // Early frame right after a second reset is dropped and flagged
    do_reset();
    repeat (5) @(negedge clock);
    wr(ADDR_CONFIG, 16'h0042, 1, 1'b0);
    repeat (50) @(negedge clock);
    rchk("early flag", ADDR_STATUS, 16'h0080);
    rchk("early dropped", ADDR_CONFIG, 16'h0023);
    wr(ADDR_STATUS, 16'h0000, 1, 1'b0);
    rchk("zero write keeps", ADDR_STATUS, 16'h0080);
    wr(ADDR_STATUS, 16'h0080, 1, 1'b0);
    rchk("one write clears", ADDR_STATUS, 16'h0000);
    $display("test early frame done");
    // Every enable code paired, codes 01 and 10 also unpaired, with checking on midway
    on_prev = 1'b0;
    for (int i = 0; i < 7; i++) begin
      if (i == 5) wr(ADDR_STATUS, 16'h0000, 1, 1'b0);
      // Wrong check byte while checking is on: write dropped
      if (i == 6) begin
        spi_host_model_i.start();
        spi_host_model_i.shift({1'b0, ADDR_CONFIG}, 8, rx);
        spi_host_model_i.shift(8'h1F, 8, rx);
        spi_host_model_i.shift(~crc8(crc8(CRC_INIT, {1'b0, ADDR_CONFIG}), 8'h1F), 8, rx);
        spi_host_model_i.stop();
        rchk("bad check kept", ADDR_CONFIG, 16'h0062);
      end
      wr(ADDR_CONFIG, {8'h00, cw[i]}, 1, on_prev);
      rchk("config", ADDR_CONFIG, {8'h00, ce[i]});
      chk("check_on", 16'(check_on), 16'(con[i]));
      on_prev = con[i];
    end
    rchk("missing check", ADDR_STATUS, 16'h0008);
    wr(ADDR_STATUS, 16'h0008, 1, 1'b0);
    rchk("check flag clear", ADDR_STATUS, 16'h0000);
    $display("test check enable done");
    // Multibyte register: partial writes refused, full write commits
    wr(ADDR_WIDE_LO, 16'h0034, 1, 1'b0);
    rd(ADDR_WIDE_LO, 2, v);
    chk("low alone", v, 16'h0000);
    wr(ADDR_WIDE_LO, 16'h1234, 2, 1'b0);
    rd(ADDR_WIDE_LO, 2, v);
    chk("full write", v, 16'h1234);
    wr(ADDR_WIDE_HI, 16'h00FF, 1, 1'b0);
    rd(ADDR_WIDE_LO, 2, v);
    chk("high alone", v, 16'h1234);
    rchk("partial flag", ADDR_STATUS, 16'h0002);
    wr(ADDR_STATUS, 16'h0002, 1, 1'b0);
    rchk("partial clear", ADDR_STATUS, 16'h0000);
    $display("test multibyte done");
    // Frame cut after three bits of a data byte, then an unmapped read
    spi_host_model_i.start();
    spi_host_model_i.shift({1'b0, ADDR_STATUS}, 8, rx);
    spi_host_model_i.shift(8'hFF, 3, rx);
    spi_host_model_i.stop();
    rchk("edge flag", ADDR_STATUS, 16'h0020);
    rchk("unmapped data", 7'h20, 16'h0000);
    rchk("unmapped flag", ADDR_STATUS, 16'h0021);
    wr(ADDR_STATUS, 16'h00FF, 1, 1'b0);
    rchk("all clear", ADDR_STATUS, 16'h0000);
    chk("sdo_oe after read", 16'(sdo_oe), 16'h0000);
    $display("test edge count done");
    final_report();
  end
endmodule : link_check_regs_bench

/* File: spi_host_model.sv */
// Behavioural serial host that frames and shifts bytes on the link
`timescale 1ns/10ps
module spi_host_model (
  input  wire logic clock,
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo
);
  // ==========================================================================
  // Idle: deselected, serial clock parked low
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end

  // Select on a falling system clock edge, then a short setup pause
  task automatic start();
    @(negedge clock);
    cs_n = 1'b0;
    #50;
  endtask : start

  // Shift n bits MSB first, mode 0: set data while low, sample on rise.
  // The last rise is held through the byte pause, because the falling
  // edge after it loads the next read byte, which needs time to settle
  task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      sdi = tx[i];
      #6 sclk = 1'b1;
      rx[i] = sdo;
      if (i == 8 - n) #250;
      else #6;
      sclk = 1'b0;
    end
    // Data line goes stale between bytes, so it is inverted
    #6 sdi = ~sdi;
  endtask : shift

  // Hold select past the last edge, release, keep the frame gap
  task automatic stop();
    #250;
    @(negedge clock);
    cs_n = 1'b1;
    #400;
  endtask : stop
endmodule : spi_host_model
